/* design/acp_regs.svh */
// Timing counts and field positions for the ADC conversion parallel port
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH
`define ACP_CLK_PERIOD_NS   5
// Conversion phase length (internal conversion clock), nanoseconds
`define ACP_CONV_TIME_NS    1450
`define ACP_CONV_CYCLES     ((`ACP_CONV_TIME_NS + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS)
// Host read slot length in cycles; covers both sync stages each way
`define ACP_RD_CYCLES       6
// Host control register offsets
`define ACP_REG_CTRL        4'h0
`define ACP_REG_STATUS      4'h1
`define ACP_REG_DATA        4'h2
`define ACP_REG_SAMPLE      4'h3
// Control register fields
`define ACP_CTRL_START      0
`define ACP_CTRL_CONT       1
`define ACP_CTRL_CODING     2
`define ACP_CTRL_PD         3
`define ACP_CTRL_RESET      4
`define ACP_CTRL_REFPD      5
`define ACP_CTRL_BUFPD      6
`define ACP_CTRL_DURING     7
`define ACP_CTRL_CFGPD      8
`endif

/* design/acp_pkg.sv */
// Types shared by both ends of the ADC conversion parallel port
package acp_pkg;
    typedef enum logic [1:0] {
        ACP_IDLE = 2'b00,
        ACP_CONV = 2'b01,
        ACP_ACQ  = 2'b10
    } acp_state_t;
    typedef enum logic [1:0] {
        ACP_H_IDLE = 2'b00,
        ACP_H_WAIT = 2'b01,
        ACP_H_READ = 2'b10
    } acp_host_state_t;
endpackage : acp_pkg

/* design/acp_if.sv */
// Pin-level interface between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface acp_if;
    logic        convert_start_n;
    logic        cs_n;
    logic        rd_n;
    logic        reset_pin;
    logic        powerdown_pin;
    logic        ref_powerdown_pin;
    logic        refbuf_powerdown_pin;
    logic        output_coding_select;
    logic        serial_parallel_select;
    logic        busy;
    logic [15:0] data_out;
    logic [15:0] data_oe;
    logic [15:0] data_host_out;
    logic [15:0] data_host_oe;
    wire  [15:0] data_bus;
    genvar i;
    for (i = 0; i < 16; i++) begin : g_bus
        assign data_bus[i] = data_oe[i] ? data_out[i]
                           : (data_host_oe[i] ? data_host_out[i] : 1'b0);
    end
    modport device (
        input  convert_start_n, cs_n, rd_n, reset_pin, powerdown_pin,
        input  ref_powerdown_pin, refbuf_powerdown_pin,
        input  output_coding_select, serial_parallel_select,
        input  data_bus,
        output busy, data_out, data_oe
    );
    modport host (
        output convert_start_n, cs_n, rd_n, reset_pin, powerdown_pin,
        output ref_powerdown_pin, refbuf_powerdown_pin,
        output output_coding_select, serial_parallel_select,
        output data_host_out, data_host_oe,
        input  busy, data_bus
    );
endinterface : acp_if
`default_nettype wire

/* design/acp_sync.sv */
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module acp_sync #(
    parameter int           W   = 1,
    // Idle level of each pin, so no false edge follows reset
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    if (W < 1) begin : g_chk
        $error("acp_sync: W must be at least 1");
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            meta_r <= RST;
            q      <= RST;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : acp_sync
`default_nettype wire

/* design/acp_device.sv */
// Converter end: conversion control, power control and parallel data port
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Both powerdown pins high disable reference and buffer
// - Temperature sensor on only with both pins low
// - Enter reduced power after each conversion phase
// - Host interface stays live during acquisition
// - Powerdown pin high powers device down
// - Finish conversion before powerdown; bus stays live
// - Config powerdown overrides pin; host ties pin (acp_host drives it from its PD control bit instead)
// - Convert-start falling edge alone starts conversion
// - Running conversion never restarted; only reset aborts it
// - Start independent of chip select and read
// - Coding select picks twos complement or binary
// - Data pins driven only when both selects low
// - Host uses chip select and read enable
// - Reset rise aborts conversion, floats data bus
// - Reset fall clears data and configuration
// - Parallel port used while select pin low
// - Serial mode shares the data pins (not served: acp_device floats the bus while the select pin is high)
// - Master mode: selects tied low, continuous data
// - Continuous mode drives bus except in reset
// - Read after conversion or during next one
// - Read during conversion within first half
module acp_device #(
    parameter int CONV_CYCLES = `ACP_CONV_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    acp_if.device     pins,
    input  wire logic [15:0] analog_sample,
    input  wire logic        cfg_powerdown,
    input  wire logic        cfg_wr,
    output logic             ref_enable,
    output logic             refbuf_enable,
    output logic             temp_enable,
    output logic             core_active,
    output logic             powered_down,
    output logic             conv_done
);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    if (CONV_CYCLES < 2) begin : g_chk
        $error("acp_device: CONV_CYCLES too small");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] pin_s;
    // Start, chip select and read enable idle high out of reset
    acp_sync #(.W(8), .RST(8'hE0)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({pins.convert_start_n, pins.cs_n, pins.rd_n,
                   pins.reset_pin, pins.powerdown_pin,
                   pins.ref_powerdown_pin, pins.refbuf_powerdown_pin,
                   pins.serial_parallel_select}),
        .q       (pin_s)
    );
    logic cnv_s, cs_s, rd_s, rst_s, pd_s, refpd_s, bufpd_s, ser_s;
    assign {cnv_s, cs_s, rd_s, rst_s, pd_s, refpd_s, bufpd_s, ser_s} = pin_s;

    logic cnv_d_r;
    logic rst_d_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnv_d_r <= 1'b1;
            rst_d_r <= 1'b0;
        end else begin
            cnv_d_r <= cnv_s;
            rst_d_r <= rst_s;
        end
    end
    // Chip select and read enable play no part in this term
    logic start_edge;
    assign start_edge = cnv_d_r & ~cnv_s;
    logic rst_fall;
    assign rst_fall = rst_d_r & ~rst_s;

    ////////////////////////////////////////////////////////////////////////
    // Configuration register: only its powerdown bit matters here
    logic cfg_pd_r;
    logic cfg_mode_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst || rst_fall) begin
            cfg_pd_r   <= 1'b0;
            cfg_mode_r <= 1'b0;
        end else if (cfg_wr) begin
            cfg_pd_r   <= cfg_powerdown;
            cfg_mode_r <= 1'b1;
        end
    end
    // Once software owns powerdown the pin is ignored
    logic pd_req;
    assign pd_req = cfg_mode_r ? cfg_pd_r : pd_s;

    assign ref_enable    = ~(refpd_s & bufpd_s) & ~refpd_s;
    assign refbuf_enable = ~(refpd_s & bufpd_s) & ~bufpd_s;
    assign temp_enable   = ~refpd_s & ~bufpd_s;

    ////////////////////////////////////////////////////////////////////////
    acp_pkg::acp_state_t state_r;
    logic [CW-1:0]       cnt_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst || rst_s) begin
            state_r <= acp_pkg::ACP_IDLE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                acp_pkg::ACP_IDLE, acp_pkg::ACP_ACQ: begin
                    if (start_edge && !pd_req) begin
                        state_r <= acp_pkg::ACP_CONV;
                        cnt_r   <= CW'(CONV_CYCLES - 1);
                    end
                end
                acp_pkg::ACP_CONV: begin
                    // Edges and powerdown are not looked at here
                    if (cnt_r == '0) begin
                        state_r <= acp_pkg::ACP_ACQ;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= acp_pkg::ACP_IDLE;
                end
            endcase
        end
    end
    logic conv_end;
    assign conv_end = (state_r == acp_pkg::ACP_CONV) && (cnt_r == '0);
    assign core_active  = (state_r == acp_pkg::ACP_CONV);
    assign powered_down = pd_req && (state_r != acp_pkg::ACP_CONV);
    assign pins.busy    = core_active;

    ////////////////////////////////////////////////////////////////////////
    // Sample is frozen at conversion start, result updated only at its end
    logic [15:0] sample_r;
    logic [15:0] result_r;
    logic        done_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sample_r <= 16'h0000;
        end else if (start_edge && state_r != acp_pkg::ACP_CONV) begin
            sample_r <= analog_sample;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst || rst_fall) begin
            result_r <= 16'h0000;
        end else if (conv_end) begin
            // Coding pin is static, so it is sampled here without sync
            result_r <= pins.output_coding_select ? sample_r
                        : {~sample_r[15], sample_r[14:0]};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= conv_end;
        end
    end
    assign conv_done = done_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus stays live in powerdown and acquisition; while selected, only reset or serial mode floats it.
    // Serial mode would take these pins over and is not served here.
    logic drive;
    assign drive = ~ser_s & ~cs_s & ~rd_s & ~rst_s;
    assign pins.data_out = result_r;
    assign pins.data_oe  = {16{drive}};
endmodule : acp_device
`default_nettype wire

/* design/acp_host.sv */
// Host end: starts conversions and reads results over the parallel port
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"
module acp_host (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    acp_if.host              pins,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata
);
    logic [15:0] ctrl_r;
    logic [15:0] data_r;
    logic [15:0] sample_count_r;
    logic        start_r;
    logic [2:0]  rcnt_r;
    acp_pkg::acp_host_state_t st_r;

    logic busy_s;
    logic [15:0] bus_s;
    acp_sync #(.W(17)) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .d       ({pins.busy, pins.data_bus}),
        .q       ({busy_s, bus_s})
    );
    logic busy_d_r;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrl_r <= 16'h0000;
        end else if (wr && addr == `ACP_REG_CTRL) begin
            ctrl_r <= wdata;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            start_r <= 1'b0;
        end else begin
            start_r <= wr && addr == `ACP_REG_CTRL && wdata[`ACP_CTRL_START];
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy_d_r <= 1'b0;
        end else begin
            busy_d_r <= busy_s;
        end
    end

    // Read slot: after conversion, or early in the next one
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r           <= acp_pkg::ACP_H_IDLE;
            rcnt_r         <= 3'h0;
            data_r         <= 16'h0000;
            sample_count_r <= 16'h0000;
        end else begin
            case (st_r)
                acp_pkg::ACP_H_IDLE: begin
                    if (start_r) begin
                        st_r <= ctrl_r[`ACP_CTRL_DURING] ? acp_pkg::ACP_H_READ
                                                         : acp_pkg::ACP_H_WAIT;
                        rcnt_r <= 3'(`ACP_RD_CYCLES - 1);
                    end
                end
                acp_pkg::ACP_H_WAIT: begin
                    if (busy_d_r && !busy_s) begin
                        st_r   <= acp_pkg::ACP_H_READ;
                        rcnt_r <= 3'(`ACP_RD_CYCLES - 1);
                    end
                end
                acp_pkg::ACP_H_READ: begin
                    if (rcnt_r == 3'h0) begin
                        data_r         <= bus_s;
                        sample_count_r <= sample_count_r + 16'h0001;
                        st_r           <= acp_pkg::ACP_H_IDLE;
                    end else begin
                        rcnt_r <= rcnt_r - 3'h1;
                    end
                end
                default: begin
                    st_r <= acp_pkg::ACP_H_IDLE;
                end
            endcase
        end
    end

    logic cont;
    assign cont = ctrl_r[`ACP_CTRL_CONT];
    // Continuous mode keeps both selects low
    assign pins.cs_n = ~(cont | (st_r == acp_pkg::ACP_H_READ));
    assign pins.rd_n = pins.cs_n;
    assign pins.convert_start_n        = ~start_r;
    assign pins.reset_pin              = ctrl_r[`ACP_CTRL_RESET];
    assign pins.powerdown_pin          = ctrl_r[`ACP_CTRL_PD];
    assign pins.ref_powerdown_pin      = ctrl_r[`ACP_CTRL_REFPD];
    assign pins.refbuf_powerdown_pin   = ctrl_r[`ACP_CTRL_BUFPD];
    assign pins.output_coding_select   = ctrl_r[`ACP_CTRL_CODING];
    assign pins.serial_parallel_select = 1'b0;
    assign pins.data_host_out          = 16'h0000;
    assign pins.data_host_oe           = 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `ACP_REG_CTRL:   rdata <= ctrl_r;
                `ACP_REG_STATUS: rdata <= {13'h0000, busy_s,
                                           st_r == acp_pkg::ACP_H_READ,
                                           st_r == acp_pkg::ACP_H_WAIT};
                `ACP_REG_DATA:   rdata <= cont ? bus_s : data_r;
                `ACP_REG_SAMPLE: rdata <= sample_count_r;
                default:         rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule : acp_host
`default_nettype wire

/* tb/acp_sva.sv */
// Pin-level assertions for the converter and host link
`timescale 1ns/1ps
`default_nettype none
module acp_sva #(
    parameter int CONV_CYCLES = 20
) (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        convert_start_n,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        reset_pin,
    input wire logic        powerdown_pin,
    input wire logic        serial_parallel_select,
    input wire logic        busy,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe
);
    // Busy run length; pins pass two flops, hence the 5-cycle windows
    logic [15:0] run_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst || !busy) begin
            run_r <= 16'h0000;
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////
    property p_start;
        $fell(convert_start_n) && !busy && !reset_pin && !powerdown_pin
            |-> ##[1:5] busy;
    endproperty
    a_start: assert property (p_start)
        else $error("start edge did not raise busy");
    property p_len;
        $fell(busy) && !reset_pin |-> run_r == CONV_CYCLES;
    endproperty
    a_len: assert property (p_len)
        else $error("conversion length wrong");
    property p_over;
        busy |-> run_r < CONV_CYCLES;
    endproperty
    a_over: assert property (p_over)
        else $error("conversion overran");
    property p_keep;
        busy && !reset_pin && run_r < CONV_CYCLES - 1 |=> busy;
    endproperty
    a_keep: assert property (p_keep)
        else $error("conversion cut short");
    property p_float;
        (cs_n || rd_n)[*5] |-> data_oe == 16'h0000;
    endproperty
    a_float: assert property (p_float)
        else $error("bus driven while deselected");
    property p_drive;
        (!cs_n && !rd_n && !reset_pin && !serial_parallel_select)[*5]
            |-> data_oe == 16'hFFFF;
    endproperty
    a_drive: assert property (p_drive)
        else $error("bus not driven while selected");
    property p_rst;
        reset_pin[*5] |-> !busy && data_oe == 16'h0000;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset did not abort and float");
    property p_hold;
        busy && $past(busy) |-> $stable(data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result changed during conversion");
    property p_clear;
        $fell(reset_pin)
            |-> ##6 data_out == 16'h0000;
    endproperty
    a_clear: assert property (p_clear)
        else $error("result not cleared by reset");
endmodule : acp_sva
`default_nettype wire

/* tb/tb_adc_conversion_parallel_port.sv */
// Bench joining host and converter ends over the pin interface
`timescale 1ns/1ps
`default_nettype none
`include "acp_regs.svh"
module tb_adc_conversion_parallel_port;
    localparam int CONV = 20;
    localparam logic [15:0] M_ST = 16'h0001 << `ACP_CTRL_START;
    localparam logic [15:0] M_CT = 16'h0001 << `ACP_CTRL_CONT;
    localparam logic [15:0] M_CD = 16'h0001 << `ACP_CTRL_CODING;
    localparam logic [15:0] M_PD = 16'h0001 << `ACP_CTRL_PD;
    localparam logic [15:0] M_RS = 16'h0001 << `ACP_CTRL_RESET;
    localparam logic [15:0] M_DR = 16'h0001 << `ACP_CTRL_DURING;
    logic        sys_clk;
    logic        nrst;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic [15:0] smp;
    logic        cfg_pd;
    logic        cfg_wr;
    logic        ref_en;
    logic        buf_en;
    logic        tmp_en;
    logic        core_act;
    logic        pd_out;
    logic        conv_dn;
    logic [15:0] done_n = 16'h0000;
    logic [31:0] rng;
    logic [15:0] prev;
    logic        rd_p = 1'b0;
    logic [15:0] exp_q[$];
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    acp_if acp_if_i ();
    acp_device #(.CONV_CYCLES(CONV)) acp_device_i (
        .sys_clk(sys_clk), .nrst(nrst), .pins(acp_if_i),
        .analog_sample(smp), .cfg_powerdown(cfg_pd), .cfg_wr(cfg_wr),
        .ref_enable(ref_en), .refbuf_enable(buf_en),
        .temp_enable(tmp_en), .core_active(core_act),
        .powered_down(pd_out), .conv_done(conv_dn));
    acp_host acp_host_i (
        .sys_clk(sys_clk), .nrst(nrst), .pins(acp_if_i), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    acp_sva #(.CONV_CYCLES(CONV)) acp_sva_i (
        .sys_clk(sys_clk), .nrst(nrst),
        .convert_start_n(acp_if_i.convert_start_n),
        .cs_n(acp_if_i.cs_n), .rd_n(acp_if_i.rd_n),
        .reset_pin(acp_if_i.reset_pin),
        .powerdown_pin(acp_if_i.powerdown_pin),
        .serial_parallel_select(acp_if_i.serial_parallel_select),
        .busy(acp_if_i.busy), .data_out(acp_if_i.data_out),
        .data_oe(acp_if_i.data_oe));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checked %0d, failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg
    // Expectation is queued; the monitor compares when data appear
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask : rd_reg
    task automatic cfg(input logic p);
        @(posedge sys_clk);
        cfg_pd <= p;
        cfg_wr <= 1'b1;
        @(posedge sys_clk);
        cfg_wr <= 1'b0;
    endtask : cfg
    // Sample is held for the whole conversion so the start moment is moot
    task automatic conv(input logic [15:0] m, input logic dur, pdm);
        logic [15:0] c;
        logic [15:0] r;
        rng = xs(rng);
        @(posedge sys_clk);
        smp <= rng[15:0];
        // A result keeps the coding that was set during its own conversion
        c = (m & M_CD) != 16'h0000 ? rng[15:0] : {~rng[15], rng[14:0]};
        r = dur ? prev : c;
        prev = c;
        wr_reg(`ACP_REG_CTRL, m | M_ST);
        if (pdm) begin
            repeat (CONV / 2) @(posedge sys_clk);
            wr_reg(`ACP_REG_CTRL, m | M_PD);
        end
        repeat (CONV + 24) @(posedge sys_clk);
        rd_reg(`ACP_REG_DATA, r);
        chk("core", {15'h0000, core_act}, 16'h0000);
        if (pdm) begin
            chk("pd", {15'h0000, pd_out}, 16'h0001);
            wr_reg(`ACP_REG_CTRL, m);
            repeat (8) @(posedge sys_clk);
        end
    endtask : conv
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin : mon
        logic [15:0] e;
        rd_p <= rd;
        cycles <= cycles + 1;
        if (conv_dn) begin
            done_n <= done_n + 16'h0001;
        end
        if (rd_p && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk("data", rdata, e);
        end
        if (cycles == 8000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        nrst = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        smp = 16'h0000;
        cfg_pd = 1'b0;
        cfg_wr = 1'b0;
        rng = 32'hAF31;
        prev = 16'h0000;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(`ACP_REG_CTRL, 16'(i) << `ACP_CTRL_REFPD);
            repeat (6) @(posedge sys_clk);
            chk("refs", {13'h0000, ref_en, buf_en, tmp_en},
                {13'h0000, !i[0], !i[1], i == 0});
        end
        for (int i = 0; i < 6; i++) begin
            conv(i[0] ? M_CD : 16'h0000, 1'b0, 1'b0);
        end
        conv(M_DR, 1'b1, 1'b0);
        conv(M_DR | M_CD, 1'b1, 1'b0);
        conv(M_CD, 1'b0, 1'b1);
        conv(M_CT | M_CD, 1'b0, 1'b0);
        cfg(1'b0);
        wr_reg(`ACP_REG_CTRL, M_PD);
        repeat (8) @(posedge sys_clk);
        chk("pd pin", {15'h0000, pd_out}, 16'h0000);
        wr_reg(`ACP_REG_CTRL, M_CT | M_ST);
        repeat (CONV / 2) @(posedge sys_clk);
        cfg(1'b1);
        wr_reg(`ACP_REG_CTRL, M_CT | M_RS);
        repeat (8) @(posedge sys_clk);
        chk("busy", {15'h0000, acp_if_i.busy}, 16'h0000);
        chk("oe", acp_if_i.data_oe, 16'h0000);
        wr_reg(`ACP_REG_CTRL, M_CT);
        repeat (12) @(posedge sys_clk);
        chk("cfg", {15'h0000, pd_out}, 16'h0000);
        rd_reg(`ACP_REG_DATA, 16'h0000);
        // Ten completed reads plus the slot after the aborted conversion
        rd_reg(`ACP_REG_SAMPLE, 16'h000B);
        repeat (4) @(posedge sys_clk);
        chk("done", done_n, 16'h000A);
        wrap_up();
    end
endmodule : tb_adc_conversion_parallel_port
`default_nettype wire
